// ==== hw/sicp_consts.svh ====
`ifndef SICP_CONSTS_SVH
`define SICP_CONSTS_SVH

// Framing bytes
`define SICP_START_MARK     8'h7e
`define SICP_END_MARK       8'h7e
`define SICP_PROTO_ID       8'h02

// Command codes
`define SICP_CRC_ON_CMD     8'h06
`define SICP_CRC_OFF_CMD    8'h07
`define SICP_COUNT_CMD      8'h08
`define SICP_TRIG_CMD       8'h09
`define SICP_CONFIG_CMD     8'h0a

// Status byte
`define SICP_COMPLETION_BIT 8'h80
`define SICP_STATUS_OK      7'h00
`define SICP_STATUS_CRC     7'h01
`define SICP_STATUS_ABSENT  7'h02
`define SICP_STATUS_BADCMD  7'h03

// CRC defaults
`define SICP_CRC_POLY       16'h1021
`define SICP_CRC_SEED       16'hffff

// Receive buffer depth (bytes after start marker)
`define SICP_RX_DEPTH       8
`define SICP_RX_IDX_W       3

// Response header length before payload (start, id, status, echo, len hi, len lo)
`define SICP_HDR_LEN        16'h0006
// Config payload: id, count, mask bytes, then 5 bytes per element
`define SICP_ELEM_BYTES     16'h0005

`endif

// ==== hw/sicp_pkg.sv ====
package sicp_pkg;

  typedef enum logic [1:0] {
    SICP_RX_IDLE  = 2'b00,
    SICP_RX_BODY  = 2'b01,
    SICP_RX_CHECK = 2'b10
  } sicp_rx_state_t;

  typedef enum logic [2:0] {
    SICP_TX_IDLE  = 3'b000,
    SICP_TX_HDR   = 3'b001,
    SICP_TX_PAY   = 3'b010,
    SICP_TX_CRCHI = 3'b011,
    SICP_TX_CRCLO = 3'b100,
    SICP_TX_END   = 3'b101
  } sicp_tx_state_t;

endpackage

// ==== hw/sicp_crc16.sv ====
`timescale 1ns/10ps
`include "sicp_consts.svh"

// Bytewise MSB-first CRC-16 accumulator
module sicp_crc16
  import sicp_pkg::*;
#(
  parameter logic [15:0] POLY = `SICP_CRC_POLY,
  parameter logic [15:0] SEED = `SICP_CRC_SEED
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        clear_i,
  input  wire logic        feed_i,
  input  wire logic [7:0]  byte_i,
  output      logic [15:0] crc_o
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [15:0] step;

  always_comb begin
    step = crc_q ^ {byte_i, 8'h00};
    for (int i = 0; i < 8; i++) begin
      step = step[15] ? ((step << 1) ^ POLY) : (step << 1);
    end
    crc_d = crc_q;
    if (clear_i) begin
      crc_d = SEED;
    end else if (feed_i) begin
      crc_d = step;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      crc_q <= SEED;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule

// ==== hw/sicp_stream_info.sv ====
`timescale 1ns/10ps
`include "sicp_consts.svh"

// Overview of operation
// - Crc-off command stops CRC check and generation
// - Crc-off response already carries no CRC
// - Bad CRC answers crc-fail, command skipped
// - Response: start, id, status, echo, length, payload, end
// - Stream count query returns one byte
// - Trigger query returns stream trigger bits
// - Trigger bits packed eight per byte, ceiling
// - Unknown stream answers stream-absent status
// - Config query returns stored stream configuration
// - Config payload: id, count, mask, elements
// - Length counts payload bytes only
// - Crc-on enables CRC from own response
// - Response CRC two bytes, high first
module sicp_stream_info
  import sicp_pkg::*;
#(
  parameter logic [15:0] CRC_POLY = `SICP_CRC_POLY,
  parameter logic [15:0] CRC_SEED = `SICP_CRC_SEED
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  output      logic [7:0] tx_data_o,
  output      logic       tx_valid_o,
  input  wire logic       tx_ready_i,
  input  wire logic [7:0] stream_count_i,
  output      logic [7:0] query_id_o,
  input  wire logic       stream_present_i,
  input  wire logic [7:0] trig_byte_count_i,
  input  wire logic [7:0] elem_count_i,
  output      logic [7:0] info_index_o,
  input  wire logic [7:0] trig_state_byte_i,
  input  wire logic [7:0] trig_mask_byte_i,
  input  wire logic [7:0] elem_byte_i,
  output      logic       crc_enabled_o,
  output      logic       busy_o
);

  // ==========================================================
  // Receive side
  // ==========================================================
  sicp_rx_state_t                  rx_state_q, rx_state_d;
  logic [7:0]                      rx_buf_q [`SICP_RX_DEPTH];
  logic [7:0]                      rx_buf_d [`SICP_RX_DEPTH];
  logic [`SICP_RX_IDX_W:0]         rx_cnt_q, rx_cnt_d;
  logic [15:0]                     rx_crc_snap_q, rx_crc_snap_d;
  logic [15:0]                     rx_crc_snap2_q, rx_crc_snap2_d;
  logic                            crc_en_q, crc_en_d;
  logic                            cmd_go;
  logic [15:0]                     rx_crc;
  logic                            rx_feed;
  logic                            rx_clear;
  logic                            tx_busy;

  // Checker sees every byte between the start and end markers
  sicp_crc16 #(
    .POLY (CRC_POLY),
    .SEED (CRC_SEED)
  ) u_rx_crc (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .clear_i (rx_clear),
    .feed_i  (rx_feed),
    .byte_i  (rx_data_i),
    .crc_o   (rx_crc)
  );

  always_comb begin
    rx_state_d     = rx_state_q;
    rx_buf_d       = rx_buf_q;
    rx_cnt_d       = rx_cnt_q;
    rx_crc_snap_d  = rx_crc_snap_q;
    rx_crc_snap2_d = rx_crc_snap2_q;
    rx_feed        = 1'b0;
    rx_clear       = 1'b0;
    cmd_go         = 1'b0;
    unique case (rx_state_q)
      SICP_RX_IDLE: begin
        rx_clear = 1'b1;
        rx_cnt_d = '0;
        if (rx_valid_i && rx_data_i == `SICP_START_MARK && !tx_busy) begin
          rx_state_d = SICP_RX_BODY;
        end
      end
      SICP_RX_BODY: begin
        if (rx_valid_i) begin
          if (rx_data_i == `SICP_END_MARK && rx_cnt_q != '0) begin
            rx_state_d = SICP_RX_CHECK;
          end else if (rx_cnt_q == (`SICP_RX_IDX_W+1)'(`SICP_RX_DEPTH)) begin
            rx_state_d = SICP_RX_IDLE;
          end else begin
            rx_buf_d[rx_cnt_q[`SICP_RX_IDX_W-1:0]] = rx_data_i;
            rx_cnt_d       = rx_cnt_q + 1'b1;
            rx_feed        = 1'b1;
            // CRC state before the last two bytes
            rx_crc_snap2_d = rx_crc_snap_q;
            rx_crc_snap_d  = rx_crc;
          end
        end
      end
      SICP_RX_CHECK: begin
        cmd_go     = 1'b1;
        rx_state_d = SICP_RX_IDLE;
      end
      default: rx_state_d = SICP_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_state_q     <= SICP_RX_IDLE;
      rx_cnt_q       <= '0;
      rx_crc_snap_q  <= '0;
      rx_crc_snap2_q <= '0;
      for (int i = 0; i < `SICP_RX_DEPTH; i++) begin
        rx_buf_q[i] <= 8'h00;
      end
    end else begin
      rx_state_q     <= rx_state_d;
      rx_buf_q       <= rx_buf_d;
      rx_cnt_q       <= rx_cnt_d;
      rx_crc_snap_q  <= rx_crc_snap_d;
      rx_crc_snap2_q <= rx_crc_snap2_d;
    end
  end

  // ==========================================================
  // Command decode
  // ==========================================================
  logic [7:0]  cmd_code;
  logic [7:0]  cmd_param;
  logic [15:0] rx_crc_rcvd;
  logic        crc_bad;
  logic [`SICP_RX_IDX_W:0] body_len;

  always_comb begin
    // Body length excluding trailing CRC bytes when enabled
    body_len    = crc_en_q ? rx_cnt_q - 2'd2 : rx_cnt_q;
    cmd_code    = rx_buf_q[1];
    cmd_param   = rx_buf_q[2];
    rx_crc_rcvd = {rx_buf_q[rx_cnt_q[`SICP_RX_IDX_W-1:0] - 2'd2],
                   rx_buf_q[rx_cnt_q[`SICP_RX_IDX_W-1:0] - 2'd1]};
    crc_bad     = crc_en_q && (rx_cnt_q < 3'd4 || rx_crc_rcvd != rx_crc_snap2_q);
  end

  assign query_id_o = cmd_param;

  // ==========================================================
  // Transmit side
  // ==========================================================
  sicp_tx_state_t tx_state_q, tx_state_d;
  logic [6:0]     status_q, status_d;
  logic [7:0]     echo_q, echo_d;
  logic [15:0]    pay_len_q, pay_len_d;
  logic [15:0]    idx_q, idx_d;
  logic           tx_crc_on_q, tx_crc_on_d;
  logic [15:0]    tx_crc;
  logic [15:0]    elem_rel;
  logic           tx_fire;

  assign tx_fire = tx_valid_o && tx_ready_i;
  assign tx_busy = tx_state_q != SICP_TX_IDLE;

  sicp_crc16 #(
    .POLY (CRC_POLY),
    .SEED (CRC_SEED)
  ) u_tx_crc (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .clear_i (tx_state_q == SICP_TX_IDLE),
    .feed_i  (tx_fire && ((tx_state_q == SICP_TX_HDR && idx_q != '0) ||
              tx_state_q == SICP_TX_PAY)),
    .byte_i  (tx_data_o),
    .crc_o   (tx_crc)
  );

  always_comb begin
    tx_state_d  = tx_state_q;
    status_d    = status_q;
    echo_d      = echo_q;
    pay_len_d   = pay_len_q;
    idx_d       = idx_q;
    tx_crc_on_d = tx_crc_on_q;
    crc_en_d    = crc_en_q;
    unique case (tx_state_q)
      SICP_TX_IDLE: begin
        if (cmd_go) begin
          echo_d      = cmd_code;
          status_d    = `SICP_STATUS_OK;
          pay_len_d   = 16'h0000;
          idx_d       = '0;
          tx_state_d  = SICP_TX_HDR;
          tx_crc_on_d = crc_en_q;
          if (rx_buf_q[0] != `SICP_PROTO_ID) begin
            tx_state_d = SICP_TX_IDLE;
          end else if (crc_bad) begin
            status_d = `SICP_STATUS_CRC;
          end else begin
            unique case (cmd_code)
              `SICP_CRC_ON_CMD: begin
                crc_en_d    = 1'b1;
                tx_crc_on_d = 1'b1;
              end
              `SICP_CRC_OFF_CMD: begin
                crc_en_d    = 1'b0;
                tx_crc_on_d = 1'b0;
              end
              `SICP_COUNT_CMD: begin
                pay_len_d = 16'h0001;
              end
              `SICP_TRIG_CMD, `SICP_CONFIG_CMD: begin
                if (body_len < 3'd3 || !stream_present_i) begin
                  status_d = `SICP_STATUS_ABSENT;
                end else if (cmd_code == `SICP_TRIG_CMD) begin
                  pay_len_d = {8'h00, trig_byte_count_i};
                end else begin
                  pay_len_d = 16'h0002 + {8'h00, trig_byte_count_i} +
                              16'(elem_count_i * `SICP_ELEM_BYTES);
                end
              end
              default: status_d = `SICP_STATUS_BADCMD;
            endcase
          end
        end
      end
      SICP_TX_HDR: begin
        if (tx_fire) begin
          idx_d = idx_q + 1'b1;
          if (idx_q == `SICP_HDR_LEN - 1'b1) begin
            idx_d = '0;
            tx_state_d = (pay_len_q != '0) ? SICP_TX_PAY :
                         tx_crc_on_q ? SICP_TX_CRCHI : SICP_TX_END;
          end
        end
      end
      SICP_TX_PAY: begin
        if (tx_fire) begin
          idx_d = idx_q + 1'b1;
          if (idx_q == pay_len_q - 1'b1) begin
            tx_state_d = tx_crc_on_q ? SICP_TX_CRCHI : SICP_TX_END;
          end
        end
      end
      SICP_TX_CRCHI: if (tx_fire) tx_state_d = SICP_TX_CRCLO;
      SICP_TX_CRCLO: if (tx_fire) tx_state_d = SICP_TX_END;
      SICP_TX_END:   if (tx_fire) tx_state_d = SICP_TX_IDLE;
      default:       tx_state_d = SICP_TX_IDLE;
    endcase
  end

  // Response byte selection
  always_comb begin
    elem_rel     = idx_q - 16'h0002 - {8'h00, trig_byte_count_i};
    info_index_o = idx_q[7:0];
    tx_valid_o   = tx_busy;
    tx_data_o    = `SICP_END_MARK;
    unique case (tx_state_q)
      SICP_TX_HDR: begin
        unique case (idx_q[2:0])
          3'd0:    tx_data_o = `SICP_START_MARK;
          3'd1:    tx_data_o = `SICP_PROTO_ID;
          3'd2:    tx_data_o = `SICP_COMPLETION_BIT | {1'b0, status_q};
          3'd3:    tx_data_o = echo_q;
          3'd4:    tx_data_o = pay_len_q[15:8];
          default: tx_data_o = pay_len_q[7:0];
        endcase
      end
      SICP_TX_PAY: begin
        if (echo_q == `SICP_COUNT_CMD) begin
          tx_data_o = stream_count_i;
        end else if (echo_q == `SICP_TRIG_CMD) begin
          tx_data_o = trig_state_byte_i;
        end else if (idx_q == 16'h0000) begin
          tx_data_o = cmd_param;
        end else if (idx_q == 16'h0001) begin
          tx_data_o = elem_count_i;
        end else if (idx_q < 16'h0002 + {8'h00, trig_byte_count_i}) begin
          info_index_o = 8'(idx_q - 16'h0002);
          tx_data_o    = trig_mask_byte_i;
        end else begin
          info_index_o = elem_rel[7:0];
          tx_data_o    = elem_byte_i;
        end
      end
      SICP_TX_CRCHI: tx_data_o = tx_crc[15:8];
      SICP_TX_CRCLO: tx_data_o = tx_crc[7:0];
      default:       tx_data_o = `SICP_END_MARK;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_state_q  <= SICP_TX_IDLE;
      status_q    <= `SICP_STATUS_OK;
      echo_q      <= 8'h00;
      pay_len_q   <= 16'h0000;
      idx_q       <= 16'h0000;
      tx_crc_on_q <= 1'b0;
      crc_en_q    <= 1'b0;
    end else begin
      tx_state_q  <= tx_state_d;
      status_q    <= status_d;
      echo_q      <= echo_d;
      pay_len_q   <= pay_len_d;
      idx_q       <= idx_d;
      tx_crc_on_q <= tx_crc_on_d;
      crc_en_q    <= crc_en_d;
    end
  end

  assign crc_enabled_o = crc_en_q;
  assign busy_o        = tx_busy || rx_state_q != SICP_RX_IDLE;

endmodule

// ==== tb/sicp_stream_info_asserts.sv ====
`timescale 1ns/10ps

module sicp_stream_info_asserts (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] rx_data_i,
  input wire logic       rx_valid_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_ready_i,
  input wire logic [7:0] stream_count_i,
  input wire logic [7:0] query_id_o,
  input wire logic       stream_present_i,
  input wire logic [7:0] trig_byte_count_i,
  input wire logic [7:0] elem_count_i,
  input wire logic [7:0] info_index_o,
  input wire logic [7:0] trig_state_byte_i,
  input wire logic [7:0] trig_mask_byte_i,
  input wire logic [7:0] elem_byte_i,
  input wire logic       crc_enabled_o,
  input wire logic       busy_o
);
  // ==========================================
  // Byte position within the outgoing frame
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  always_comb begin
    idx_d = idx_q;
    if (reset_i || !tx_valid_o) idx_d = 8'h00;
    else if (tx_ready_i) idx_d = idx_q + 8'h01;
  end
  always_ff @(posedge clk_i) idx_q <= idx_d;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_take;
    tx_valid_o && tx_ready_i;
  endsequence
  sequence s_stall;
    tx_valid_o && !tx_ready_i;
  endsequence

  // ==========================================
  // Properties
  AST_RESET_IDLE: assert property ($fell(reset_i) |-> !tx_valid_o && !crc_enabled_o && !busy_o)
    else $error("outputs not idle after reset");
  AST_TX_HOLD: assert property (s_stall |=> tx_valid_o && $stable(tx_data_o))
    else $error("response byte dropped while stalled");
  AST_FIRST_START: assert property ($rose(tx_valid_o) |-> tx_data_o == 8'h7e)
    else $error("response does not open with start marker");
  AST_PROTO_BYTE: assert property ((s_take ##0 idx_q == 8'h01) |-> tx_data_o == 8'h02)
    else $error("second response byte not protocol id");
  AST_COMPLETION: assert property ((s_take ##0 idx_q == 8'h02) |-> tx_data_o[7])
    else $error("completion flag clear");
  AST_END_MARK: assert property ($fell(tx_valid_o) && !$past(reset_i)
    |-> $past(tx_data_o) == 8'h7e && $past(tx_ready_i))
    else $error("response not closed by end marker");
  AST_TX_IN_BUSY: assert property (tx_valid_o |-> busy_o)
    else $error("sending while not busy");
  AST_START_BUSY: assert property (!busy_o && rx_valid_i && rx_data_i == 8'h7e |=> busy_o)
    else $error("start marker not taken");
  AST_CRC_CHANGE: assert property ($changed(crc_enabled_o) |-> $past(busy_o))
    else $error("crc mode changed outside a command");
endmodule

bind sicp_stream_info sicp_stream_info_asserts sicp_stream_info_asserts_inst (
  .clk_i(clk_i), .reset_i(reset_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .stream_count_i(stream_count_i), .query_id_o(query_id_o),
  .stream_present_i(stream_present_i), .trig_byte_count_i(trig_byte_count_i),
  .elem_count_i(elem_count_i), .info_index_o(info_index_o),
  .trig_state_byte_i(trig_state_byte_i), .trig_mask_byte_i(trig_mask_byte_i),
  .elem_byte_i(elem_byte_i), .crc_enabled_o(crc_enabled_o), .busy_o(busy_o)
);

// ==== tb/sicp_host_model.sv ====
`timescale 1ns/10ps
`include "sicp_consts.svh"

module sicp_host_model #(
  parameter logic [15:0] CRC_POLY = `SICP_CRC_POLY,
  parameter logic [15:0] CRC_SEED = `SICP_CRC_SEED
) (
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output      logic       tx_ready_o,
  output      logic [7:0] rx_data_o,
  output      logic       rx_valid_o
);
  logic [7:0] got[$];
  logic       ph;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
    ph = 1'b0;
  end
  // Stall every other cycle in slow mode
  always @(negedge clk_i) begin
    ph <= !ph;
    tx_ready_o <= !slow_i || ph;
  end
  always @(posedge clk_i) if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);

  function automatic logic [15:0] crc16(input logic [7:0] d[$]);
    logic [15:0] c;
    c = CRC_SEED;
    foreach (d[i]) begin
      c = c ^ {d[i], 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Idle line shows inverse of last byte
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    rx_data_o = b;
    rx_valid_o = 1'b1;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~b;
  endtask

  // Mode 0 no CRC, 1 good CRC, 2 corrupted CRC
  task automatic send_cmd(input logic [7:0] body[$], input logic [1:0] mode);
    logic [15:0] c;
    c = crc16(body) ^ {15'h0000, mode[1]};
    send(8'h7e);
    foreach (body[i]) send(body[i]);
    if (mode != 2'h0) begin
      send(c[15:8]);
      send(c[7:0]);
    end
    send(8'h7e);
  endtask
endmodule

// ==== tb/sicp_stream_info_bench.sv ====
`timescale 1ns/10ps
`include "sicp_consts.svh"

module sicp_stream_info_bench;
  logic clk_i, reset_i, slow, tx_valid_o, tx_ready_i, rx_valid_i, crc_enabled_o, busy_o;
  logic [7:0] rx_data_i, tx_data_o, query_id_o, info_index_o;
  logic [7:0] elem_tab [10] = '{8'h10, 8'h00, 8'h04, 8'h00, 8'h12,
                                8'h11, 8'h23, 8'h45, 8'h95, 8'h13};
  logic [7:0] none_q[$], cfg_q[$];
  int         miscompares, cmp_count, cyc;
  localparam logic [7:0] ST_OK  = {1'b1, `SICP_STATUS_OK};
  localparam logic [7:0] ST_CRC = {1'b1, `SICP_STATUS_CRC};
  localparam logic [7:0] ST_ABS = {1'b1, `SICP_STATUS_ABSENT};
  localparam logic [7:0] ST_BAD = {1'b1, `SICP_STATUS_BADCMD};

  sicp_stream_info sicp_stream_info_inst (
    .clk_i(clk_i), .reset_i(reset_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .stream_count_i(8'h05), .query_id_o(query_id_o),
    .stream_present_i(query_id_o === 8'hf0), .trig_byte_count_i(8'h02),
    .elem_count_i(8'h02), .info_index_o(info_index_o),
    .trig_state_byte_i(info_index_o == 8'h00 ? 8'hf9 : 8'h02),
    .trig_mask_byte_i(info_index_o == 8'h00 ? 8'h03 : 8'h00),
    .elem_byte_i(info_index_o < 8'h0a ? elem_tab[info_index_o[3:0]] : 8'h00),
    .crc_enabled_o(crc_enabled_o), .busy_o(busy_o)
  );
  sicp_host_model host_inst (
    .clk_i(clk_i), .slow_i(slow), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // One command, then the whole response checked byte by byte
  task automatic xact(input logic [7:0] body[$], input logic [1:0] mode, input logic rsp_crc,
                      input logic [7:0] st, input logic [7:0] pay[$]);
    logic [7:0]  e[$];
    logic [15:0] c;
    int          n;
    host_inst.got.delete();
    host_inst.send_cmd(body, mode);
    n = 0;
    repeat (3) @(negedge clk_i);
    while (busy_o !== 1'b0 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    e = {8'h02, st, body[1], 8'h00, 8'(pay.size())};
    e = {e, pay};
    if (rsp_crc) begin
      c = host_inst.crc16(e);
      e = {e, c[15:8], c[7:0]};
    end
    e = {8'h7e, e, 8'h7e};
    chk_int(host_inst.got.size(), e.size());
    foreach (e[i]) if (i < host_inst.got.size()) chk_byte(host_inst.got[i], e[i]);
  endtask

  initial begin
    cyc = 0;
    miscompares = 0;
    cmp_count = 0;
    slow = 1'b0;
    reset_i = 1'b1;
    cfg_q = {8'hf0, 8'h02, 8'h03, 8'h00, 8'h10, 8'h00, 8'h04, 8'h00, 8'h12,
             8'h11, 8'h23, 8'h45, 8'h95, 8'h13};
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    chk_byte({7'h00, crc_enabled_o}, 8'h00);
    host_inst.send(8'h08);
    xact('{8'h02, 8'h08}, 2'h0, 1'b0, ST_OK, '{8'h05});
    xact('{8'h02, 8'h09, 8'hf0}, 2'h0, 1'b0, ST_OK, '{8'hf9, 8'h02});
    xact('{8'h02, 8'h0a, 8'hf0}, 2'h0, 1'b0, ST_OK, cfg_q);
    xact('{8'h02, 8'h09, 8'h33}, 2'h0, 1'b0, ST_ABS, none_q);
    xact('{8'h02, 8'h0a, 8'h34}, 2'h0, 1'b0, ST_ABS, none_q);
    slow = 1'b1;
    xact('{8'h02, 8'h06}, 2'h0, 1'b1, ST_OK, none_q);
    chk_byte({7'h00, crc_enabled_o}, 8'h01);
    xact('{8'h02, 8'h0a, 8'hf0}, 2'h1, 1'b1, ST_OK, cfg_q);
    xact('{8'h02, 8'h08}, 2'h2, 1'b1, ST_CRC, none_q);
    xact('{8'h02, 8'h07}, 2'h1, 1'b0, ST_OK, none_q);
    chk_byte({7'h00, crc_enabled_o}, 8'h00);
    slow = 1'b0;
    xact('{8'h02, 8'h0b}, 2'h0, 1'b0, ST_BAD, none_q);
    host_inst.got.delete();
    host_inst.send_cmd('{8'h03, 8'h08}, 2'h0);
    repeat (20) @(negedge clk_i);
    chk_int(host_inst.got.size(), 0);
    xact('{8'h02, 8'h08}, 2'h0, 1'b0, ST_OK, '{8'h05});
    wrap_up();
  end
endmodule
